/* inc/dsp_pkg.sv */
// shared constants for the drive supervision parameter bank
package dsp_pkg;

   // parameter addresses on the parameter port
   localparam logic [15:0] ADDR_STARTUP = 16'h0138;
   localparam logic [15:0] ADDR_COMMUT = 16'h050a;
   localparam logic [15:0] ADDR_UPPER_LIM = 16'h0608;
   localparam logic [15:0] ADDR_LOWER_LIM = 16'h060a;
   localparam logic [15:0] ADDR_TOL = 16'h1112;
   localparam logic [15:0] ADDR_DWELL = 16'h1114;
   localparam logic [15:0] ADDR_TOUT = 16'h1116;
   localparam logic [15:0] ADDR_MODES = 16'h1b28;

   // user position range, signed user units
   localparam logic signed [31:0] USR_POS_MAX = 32'sh7fffffff;
   localparam logic signed [31:0] USR_POS_MIN = 32'sh80000000;

   // 16-bit parameter limits and reset values
   localparam logic [15:0] TOL_MAX = 16'h7fff;   // 3.2767 rev in 0.0001 rev steps
   localparam logic [15:0] TOL_RESET = 16'h000a; // 0.0010 rev
   localparam logic [15:0] DWELL_MAX = 16'h7fff; // 32767 ms
   localparam logic [15:0] DWELL_RESET = 16'h0000;
   localparam logic [15:0] TOUT_MAX = 16'h3e80;  // 16000 ms
   localparam logic [15:0] TOUT_RESET = 16'h0000;
   localparam logic [15:0] COMMUT_RESET = 16'h0001;
   localparam logic [15:0] PARAM_OFF = 16'h0000; // zero disables a monitor

   // start-up message bit positions
   localparam int unsigned SU_FIRST_SETUP = 0;
   localparam int unsigned SU_MOTOR_CHG = 1;
   localparam int unsigned SU_NV_CORRUPT = 2;
   localparam int unsigned SU_NO_MOTOR = 3;

   // supported-modes bit positions
   localparam int unsigned MD_PROF_POS = 0;
   localparam int unsigned MD_PROF_VEL = 2;
   localparam int unsigned MD_HOMING = 5;
   localparam int unsigned MD_JOG = 16;
   localparam int unsigned MD_EGEAR = 17;
   localparam int unsigned MD_CURRENT = 18;
   localparam int unsigned MD_SPEED = 19;
   localparam int unsigned MD_POSITION = 20;
   localparam int unsigned MD_TUNING = 21;
   localparam int unsigned MD_OSC = 22;

   // modes of the basic controller variant (no fieldbus profile modes)
   localparam logic [31:0] MODES_BASIC = (32'h1 << MD_JOG) | (32'h1 << MD_EGEAR)
      | (32'h1 << MD_CURRENT) | (32'h1 << MD_SPEED) | (32'h1 << MD_POSITION)
      | (32'h1 << MD_TUNING) | (32'h1 << MD_OSC);
   // modes of the fieldbus controller variant
   localparam logic [31:0] MODES_FIELDBUS = MODES_BASIC | (32'h1 << MD_PROF_POS)
      | (32'h1 << MD_PROF_VEL) | (32'h1 << MD_HOMING);

   // millisecond time base
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // counter steps
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_SAT = 16'hffff;

endpackage

/* design/dsp_ms_tick.sv */
`timescale 1ns/1ns
// one-cycle tick every millisecond of core clock
module dsp_ms_tick #(
   parameter int unsigned CYCLES = dsp_pkg::MS_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   output logic tick
);
   // last count value before wrap
   localparam logic [15:0] LAST = 16'(CYCLES - 1);

   typedef struct packed {
      logic [15:0] cnt; // cycle counter
      logic tick;       // wrap pulse
   } dsp_tick_state_type;

   dsp_tick_state_type st_r;
   dsp_tick_state_type st_nxt;

   // count up, wrap and pulse
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == LAST) begin
         st_nxt.cnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + dsp_pkg::CNT_ONE;
      end
   end

   // state register, frozen while ce low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;
endmodule

/* design/dsp_ms_cnt.sv */
`timescale 1ns/1ns
// saturating millisecond counter with clear and run
module dsp_ms_cnt (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic clear,
   input wire logic run,
   input wire logic tick,
   output logic [15:0] count
);
   typedef struct packed {
      logic [15:0] cnt; // elapsed milliseconds
   } dsp_cnt_state_type;

   dsp_cnt_state_type st_r;
   dsp_cnt_state_type st_nxt;

   // clear beats counting; stop at full scale
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.cnt = '0;
      end else if (run && tick && st_r.cnt != dsp_pkg::CNT_SAT) begin
         st_nxt.cnt = st_r.cnt + dsp_pkg::CNT_ONE;
      end
   end

   // state register, frozen while ce low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.cnt;
endmodule

/* design/dsp_top.sv */
`timescale 1ns/1ns
module dsp_top #(
   parameter int unsigned TICK_CYCLES = dsp_pkg::MS_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [15:0] par_addr,
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [31:0] par_wdata,
   output logic [31:0] par_rdata,
   output logic par_rvalid,
   output logic par_addr_err,
   input wire logic first_setup_evt,
   input wire logic motor_changed_evt,
   input wire logic nv_data_corrupt,
   input wire logic motor_absent,
   input wire logic ctrl_variant,
   input wire logic homing_done,
   input wire logic target_reached,
   input wire logic profile_done,
   input wire logic [31:0] ctrl_dev,
   input wire logic [31:0] actual_pos,
   output logic commut_mon_en,
   output logic standstill,
   output logic standstill_tout_err,
   output logic lim_pos_hit,
   output logic lim_neg_hit
);

   // whole state of the bank
   typedef struct packed {
      logic [31:0] upper_lim;   // upper soft position limit
      logic [31:0] lower_lim;   // lower soft position limit
      logic [15:0] tol;         // standstill tolerance
      logic [15:0] dwell;       // standstill dwell time, ms
      logic [15:0] tout;        // standstill timeout, ms
      logic [15:0] commut;      // commutation monitor switch
      logic first_setup;        // sticky start-up flag
      logic motor_chg;          // sticky start-up flag
      logic nv_bad;             // live start-up status
      logic no_motor;           // live start-up status
      logic [31:0] modes;       // supported modes of fitted variant
      logic strap_done;         // variant captured
      logic [31:0] rdata;       // read answer
      logic rvalid;             // read answer pulse
      logic addr_err;           // unmapped access pulse
      logic in_win;             // deviation inside tolerance
      logic still;              // standstill recognised
      logic tout_run;           // timeout supervision active
      logic tout_err;           // timeout expired before standstill
      logic lim_pos;            // above upper limit
      logic lim_neg;            // below lower limit
   } dsp_state_type;

   dsp_state_type st_r;
   dsp_state_type st_nxt;

   // reset image of the state
   localparam dsp_state_type ST_RESET = '{
      upper_lim: dsp_pkg::USR_POS_MAX,
      lower_lim: dsp_pkg::USR_POS_MIN,
      tol: dsp_pkg::TOL_RESET,
      dwell: dsp_pkg::DWELL_RESET,
      tout: dsp_pkg::TOUT_RESET,
      commut: dsp_pkg::COMMUT_RESET,
      default: '0
   };

   logic ms_tick;            // millisecond pulse
   logic [15:0] dwell_cnt;   // ms spent inside the window
   logic [15:0] tout_cnt;    // ms since motion end
   logic dwell_en;           // standstill processing active
   logic tout_en;            // timeout check active
   logic move_end;           // motion end event
   logic [32:0] dev_abs;     // magnitude of deviation
   logic win_now;            // current window comparison
   logic dwell_clr;          // restart dwell count
   logic tout_clr;           // restart timeout count

   // millisecond time base
   dsp_ms_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .tick(ms_tick)
   );

   // dwell time counter
   dsp_ms_cnt u_dwell (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .clear(dwell_clr),
      .run(st_r.in_win),
      .tick(ms_tick),
      .count(dwell_cnt)
   );

   // timeout counter
   dsp_ms_cnt u_tout (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .clear(tout_clr),
      .run(st_r.tout_run),
      .tick(ms_tick),
      .count(tout_cnt)
   );

   // monitor enables and window test
   always_comb begin
      dwell_en = st_r.dwell != dsp_pkg::PARAM_OFF;
      tout_en = dwell_en && st_r.tout != dsp_pkg::PARAM_OFF;
      move_end = target_reached || profile_done;
      // widen before negating so the most negative value is safe
      if (ctrl_dev[31]) begin
         dev_abs = 33'h0 - {ctrl_dev[31], ctrl_dev};
      end else begin
         dev_abs = {1'b0, ctrl_dev};
      end
      win_now = dev_abs <= {17'h0, st_r.tol};
      dwell_clr = !dwell_en || !win_now;
      tout_clr = move_end || !st_r.tout_run;
   end

   // next state: parameter writes, reads and supervision
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.addr_err = 1'b0;

      // catch the controller variant strap once after reset
      if (!st_r.strap_done) begin
         st_nxt.strap_done = 1'b1;
         if (ctrl_variant) begin
            st_nxt.modes = dsp_pkg::MODES_FIELDBUS;
         end else begin
            st_nxt.modes = dsp_pkg::MODES_BASIC;
         end
      end

      // live start-up status bits
      st_nxt.nv_bad = nv_data_corrupt;
      st_nxt.no_motor = motor_absent;

      // confirmation clears sticky bits; reserved bits ignored
      if (par_wr && par_addr == dsp_pkg::ADDR_STARTUP) begin
         if (par_wdata[dsp_pkg::SU_FIRST_SETUP]) begin
            st_nxt.first_setup = 1'b0;
         end
         if (par_wdata[dsp_pkg::SU_MOTOR_CHG]) begin
            st_nxt.motor_chg = 1'b0;
         end
      end
      // a new event wins over a confirmation in the same cycle
      if (first_setup_evt) begin
         st_nxt.first_setup = 1'b1;
      end
      if (motor_changed_evt) begin
         st_nxt.motor_chg = 1'b1;
      end

      // parameter write decode
      if (par_wr) begin
         if (par_addr == dsp_pkg::ADDR_STARTUP) begin
            // handled above
         end else if (par_addr == dsp_pkg::ADDR_COMMUT) begin
            st_nxt.commut = par_wdata[15:0];
         end else if (par_addr == dsp_pkg::ADDR_UPPER_LIM) begin
            // clamp into the user range
            if ($signed(par_wdata) > dsp_pkg::USR_POS_MAX) begin
               st_nxt.upper_lim = dsp_pkg::USR_POS_MAX;
            end else if ($signed(par_wdata) < dsp_pkg::USR_POS_MIN) begin
               st_nxt.upper_lim = dsp_pkg::USR_POS_MIN;
            end else begin
               st_nxt.upper_lim = par_wdata;
            end
         end else if (par_addr == dsp_pkg::ADDR_LOWER_LIM) begin
            // same clamp as the upper limit
            if ($signed(par_wdata) > dsp_pkg::USR_POS_MAX) begin
               st_nxt.lower_lim = dsp_pkg::USR_POS_MAX;
            end else if ($signed(par_wdata) < dsp_pkg::USR_POS_MIN) begin
               st_nxt.lower_lim = dsp_pkg::USR_POS_MIN;
            end else begin
               st_nxt.lower_lim = par_wdata;
            end
         end else if (par_addr == dsp_pkg::ADDR_TOL) begin
            // tolerance saturates at its maximum
            if (par_wdata[31:16] != 16'h0 || par_wdata[15:0] > dsp_pkg::TOL_MAX) begin
               st_nxt.tol = dsp_pkg::TOL_MAX;
            end else begin
               st_nxt.tol = par_wdata[15:0];
            end
         end else if (par_addr == dsp_pkg::ADDR_DWELL) begin
            // dwell time saturates at its maximum
            if (par_wdata[31:16] != 16'h0 || par_wdata[15:0] > dsp_pkg::DWELL_MAX) begin
               st_nxt.dwell = dsp_pkg::DWELL_MAX;
            end else begin
               st_nxt.dwell = par_wdata[15:0];
            end
         end else if (par_addr == dsp_pkg::ADDR_TOUT) begin
            // timeout saturates at its maximum
            if (par_wdata[31:16] != 16'h0 || par_wdata[15:0] > dsp_pkg::TOUT_MAX) begin
               st_nxt.tout = dsp_pkg::TOUT_MAX;
            end else begin
               st_nxt.tout = par_wdata[15:0];
            end
         end else if (par_addr == dsp_pkg::ADDR_MODES) begin
            // read-only word, write dropped
         end else begin
            st_nxt.addr_err = 1'b1; // unmapped write
         end
      end

      // parameter read decode, answer one cycle later
      if (par_rd) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = '0;
         if (par_addr == dsp_pkg::ADDR_STARTUP) begin
            // reserved bits stay zero
            st_nxt.rdata[dsp_pkg::SU_FIRST_SETUP] = st_r.first_setup;
            st_nxt.rdata[dsp_pkg::SU_MOTOR_CHG] = st_r.motor_chg;
            st_nxt.rdata[dsp_pkg::SU_NV_CORRUPT] = st_r.nv_bad;
            st_nxt.rdata[dsp_pkg::SU_NO_MOTOR] = st_r.no_motor;
         end else if (par_addr == dsp_pkg::ADDR_COMMUT) begin
            st_nxt.rdata = {16'h0, st_r.commut};
         end else if (par_addr == dsp_pkg::ADDR_UPPER_LIM) begin
            st_nxt.rdata = st_r.upper_lim;
         end else if (par_addr == dsp_pkg::ADDR_LOWER_LIM) begin
            st_nxt.rdata = st_r.lower_lim;
         end else if (par_addr == dsp_pkg::ADDR_TOL) begin
            st_nxt.rdata = {16'h0, st_r.tol};
         end else if (par_addr == dsp_pkg::ADDR_DWELL) begin
            st_nxt.rdata = {16'h0, st_r.dwell};
         end else if (par_addr == dsp_pkg::ADDR_TOUT) begin
            st_nxt.rdata = {16'h0, st_r.tout};
         end else if (par_addr == dsp_pkg::ADDR_MODES) begin
            st_nxt.rdata = st_r.modes;
         end else begin
            st_nxt.addr_err = 1'b1; // unmapped read, data zero
         end
      end

      // window flag only while processing is enabled
      st_nxt.in_win = dwell_en && win_now;

      // standstill once the dwell time has passed inside the window
      st_nxt.still = st_r.in_win && win_now && dwell_en
         && dwell_cnt >= st_r.dwell;

      // timeout supervision
      if (!tout_en) begin
         st_nxt.tout_run = 1'b0;
         st_nxt.tout_err = 1'b0;
      end else if (move_end) begin
         st_nxt.tout_run = 1'b1;
         st_nxt.tout_err = 1'b0;
      end else if (st_r.tout_run && st_r.still) begin
         st_nxt.tout_run = 1'b0; // standstill reached in time
      end else if (st_r.tout_run && tout_cnt >= st_r.tout) begin
         st_nxt.tout_run = 1'b0;
         st_nxt.tout_err = 1'b1;
      end

      // soft limit monitor, only after homing
      if (homing_done) begin
         st_nxt.lim_pos = $signed(actual_pos) > $signed(st_r.upper_lim);
         st_nxt.lim_neg = $signed(actual_pos) < $signed(st_r.lower_lim);
      end else begin
         st_nxt.lim_pos = 1'b0;
         st_nxt.lim_neg = 1'b0;
      end
   end

   // state register, frozen while ce low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= ST_RESET;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign par_rdata = st_r.rdata;
   assign par_rvalid = st_r.rvalid;
   assign par_addr_err = st_r.addr_err;
   assign commut_mon_en = st_r.commut[0];
   assign standstill = st_r.still;
   assign standstill_tout_err = st_r.tout_err;
   assign lim_pos_hit = st_r.lim_pos;
   assign lim_neg_hit = st_r.lim_neg;

endmodule

/* tb/dsp_top_props.sv */
`timescale 1ns/1ns
// port-level checks of the drive supervision parameter bank
module dsp_top_props #(
   parameter int unsigned TICK_CYCLES = dsp_pkg::MS_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [15:0] par_addr,
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [31:0] par_wdata,
   input wire logic [31:0] par_rdata,
   input wire logic par_rvalid,
   input wire logic par_addr_err,
   input wire logic first_setup_evt,
   input wire logic motor_changed_evt,
   input wire logic nv_data_corrupt,
   input wire logic motor_absent,
   input wire logic ctrl_variant,
   input wire logic homing_done,
   input wire logic target_reached,
   input wire logic profile_done,
   input wire logic [31:0] ctrl_dev,
   input wire logic [31:0] actual_pos,
   input wire logic commut_mon_en,
   input wire logic standstill,
   input wire logic standstill_tout_err,
   input wire logic lim_pos_hit,
   input wire logic lim_neg_hit
);
   logic [3:0] su_r; // expected start-up bits
   logic [3:0] su_nxt;
   logic [15:0] dwell_r; // expected dwell setting
   logic [15:0] dwell_nxt;
   logic wr_su; // write to the start-up word
   logic mapped; // address names a parameter
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // shadow of start-up bits and dwell setting
   always_comb begin
      mapped = par_addr inside {dsp_pkg::ADDR_STARTUP, dsp_pkg::ADDR_COMMUT,
         dsp_pkg::ADDR_UPPER_LIM, dsp_pkg::ADDR_LOWER_LIM, dsp_pkg::ADDR_TOL,
         dsp_pkg::ADDR_DWELL, dsp_pkg::ADDR_TOUT, dsp_pkg::ADDR_MODES};
      wr_su = ce && par_wr && (par_addr == dsp_pkg::ADDR_STARTUP);
      su_nxt = su_r;
      dwell_nxt = dwell_r;
      if (ce) begin
         // an event in the confirm cycle wins
         su_nxt[0] = first_setup_evt | (su_r[0] & ~(wr_su & par_wdata[0]));
         su_nxt[1] = motor_changed_evt | (su_r[1] & ~(wr_su & par_wdata[1]));
         su_nxt[3:2] = {motor_absent, nv_data_corrupt};
      end
      if (ce && par_wr && (par_addr == dsp_pkg::ADDR_DWELL)) begin
         dwell_nxt = (par_wdata[31:16] != 16'h0000 || par_wdata[15:0] > dsp_pkg::DWELL_MAX)
            ? dsp_pkg::DWELL_MAX : par_wdata[15:0];
      end
   end
   // shadow registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         su_r <= 4'h0;
         dwell_r <= 16'h0000;
      end else begin
         su_r <= su_nxt;
         dwell_r <= dwell_nxt;
      end
   end
   sequence rd_at(logic [15:0] a);
      ce && par_rd && (par_addr == a);
   endsequence
   sequence far_dev;
      ce && ($signed(ctrl_dev) > 32'sh00007fff || $signed(ctrl_dev) < -32'sh00007fff);
   endsequence
   rd_answer_a: assert property (ce && par_rd |=> par_rvalid)
      else $error("read gave no answer");
   addr_err_a: assert property (ce && (par_rd || par_wr) |=> par_addr_err == !$past(mapped))
      else $error("address error flag wrong");
   unmapped_zero_a: assert property (ce && par_rd && !mapped |=> par_rdata == 32'h00000000)
      else $error("unmapped read not zero");
   startup_word_a: assert property (rd_at(dsp_pkg::ADDR_STARTUP) |=>
      par_rdata == {28'h0000000, $past(su_r)}) else $error("start-up word wrong");
   modes_word_a: assert property (rd_at(dsp_pkg::ADDR_MODES) |=> par_rdata ==
      ($past(ctrl_variant) ? dsp_pkg::MODES_FIELDBUS : dsp_pkg::MODES_BASIC))
      else $error("modes word wrong");
   leave_window_a: assert property (far_dev ##1 ce |=> !standstill)
      else $error("standstill outside window");
   dwell_off_a: assert property ((ce && dwell_r == 16'h0000) ##1 ce |=>
      !standstill && !standstill_tout_err) else $error("monitor active with dwell zero");
   tout_restart_a: assert property (ce && (target_reached || profile_done) |=>
      !standstill_tout_err) else $error("timeout error not cleared at start");
   lim_unhomed_a: assert property (ce && !homing_done |=>
      !lim_pos_hit && !lim_neg_hit) else $error("limit hit before homing");
endmodule
bind dsp_top dsp_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_dsp_top_props (.*);

/* tb/dsp_master.sv */
`timescale 1ns/1ns
// fieldbus master reading and writing drive parameters
module dsp_master (
   input wire logic core_clk,
   output logic [15:0] par_addr,
   output logic par_wr,
   output logic par_rd,
   output logic [31:0] par_wdata,
   input wire logic [31:0] par_rdata,
   input wire logic par_rvalid,
   input wire logic par_addr_err
);
   // idle port at time zero
   initial begin
      par_addr = 16'h0000;
      par_wr = 1'b0;
      par_rd = 1'b0;
      par_wdata = 32'h00000000;
   end
   // one write, held for the edge that takes it
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      par_addr <= a;
      par_wdata <= d;
      par_wr <= 1'b1;
      @(posedge core_clk);
      par_wr <= 1'b0;
      par_wdata <= ~d; // released data stops showing the value
   endtask
   // one read, answer taken one cycle after the request edge
   task automatic rd(input logic [15:0] a, output logic [31:0] q, output logic v,
      output logic e);
      @(posedge core_clk);
      par_addr <= a;
      par_rd <= 1'b1;
      @(posedge core_clk);
      par_rd <= 1'b0;
      #1;
      q = par_rdata;
      v = par_rvalid;
      e = par_addr_err;
   endtask
   // confirmation of pending start-up messages
   task automatic confirm(input logic [31:0] bits);
      wr(dsp_pkg::ADDR_STARTUP, bits);
   endtask
endmodule

/* tb/drive_supervision_params_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
// self-checking bench of the parameter bank
module drive_supervision_params_tb_top;
   localparam int unsigned TICK = 10; // short millisecond for simulation
   localparam logic [15:0] ADDRS [8] = '{dsp_pkg::ADDR_STARTUP, dsp_pkg::ADDR_COMMUT,
      dsp_pkg::ADDR_UPPER_LIM, dsp_pkg::ADDR_LOWER_LIM, dsp_pkg::ADDR_TOL,
      dsp_pkg::ADDR_DWELL, dsp_pkg::ADDR_TOUT, dsp_pkg::ADDR_MODES};
   localparam logic [31:0] RSTV [8] = '{32'h00000000, 32'h00000001, 32'h7fffffff,
      32'h80000000, 32'h0000000a, 32'h00000000, 32'h00000000, dsp_pkg::MODES_FIELDBUS};
   localparam logic [31:0] CORNER [5] = '{32'h00007fff, 32'h00008000, 32'h00003e80,
      32'h00003e81, 32'h00010000};
   logic core_clk, resetn, ce, par_wr, par_rd, par_rvalid, par_addr_err;
   logic first_setup_evt, motor_changed_evt, nv_data_corrupt, motor_absent;
   logic ctrl_variant, homing_done, target_reached, profile_done, commut_mon_en;
   logic standstill, standstill_tout_err, lim_pos_hit, lim_neg_hit, v, e;
   logic [15:0] par_addr;
   logic [31:0] par_wdata, par_rdata, ctrl_dev, actual_pos, q, d;
   int err_count = 0;
   int cmp_count = 0;
   int i, j, c;
   dsp_top #(.TICK_CYCLES(TICK)) u_dsp_top (.*);
   dsp_master u_dsp_master (.*);
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   // expected read-back after a write to table entry k
   function automatic logic [31:0] exp_par(input int k, input logic [31:0] w);
      logic [15:0] m;
      m = (k == 4) ? dsp_pkg::TOL_MAX : (k == 5) ? dsp_pkg::DWELL_MAX : dsp_pkg::TOUT_MAX;
      if (k < 4) return w; // limits span the full user range
      if (w[31:16] != 16'h0000 || w[15:0] > m) return {16'h0000, m};
      return {16'h0000, w[15:0]};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [31:0] x);
      u_dsp_master.rd(a, q, v, e);
      `CHK(v, 1'b1)
      `CHK(q, x)
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // bounded wait for standstill (0) or timeout error (1)
   task automatic wait_hi(input int which, input int n);
      c = 0;
      while (((which == 0) ? standstill : standstill_tout_err) !== 1'b1) begin
         if (c == n) begin
            err_count++;
            $display("[ERR] %0t wait ran out", $time);
            tally_and_finish();
         end
         @(posedge core_clk);
         #1;
         c++;
      end
      cmp_count++;
   endtask
   task automatic done(input string name);
      $display("test %s done, mismatches %0d", name, err_count);
   endtask
   // main sequence
   initial begin
      core_clk = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      {first_setup_evt, motor_changed_evt, nv_data_corrupt, motor_absent} = 4'h0;
      {homing_done, target_reached, profile_done} = 3'h0;
      ctrl_variant = 1'b1;
      ctrl_dev = 32'h00100000;
      actual_pos = 32'h00000000;
      void'($urandom(88652));
      cyc(4);
      resetn <= 1'b1;
      cyc(2);
      for (i = 0; i < 8; i++) rchk(ADDRS[i], RSTV[i]);
      `CHK(commut_mon_en, 1'b1)
      done("reset");
      for (i = 2; i < 7; i++) begin
         for (j = 0; j < 9; j++) begin
            d = (j < 5) ? CORNER[j] : $urandom();
            if (j == 8) d[31:16] = 16'h0000;
            u_dsp_master.wr(ADDRS[i], d);
            rchk(ADDRS[i], exp_par(i, d));
         end
      end
      done("write_clamp");
      u_dsp_master.wr(dsp_pkg::ADDR_MODES, 32'h00000000);
      rchk(dsp_pkg::ADDR_MODES, dsp_pkg::MODES_FIELDBUS);
      u_dsp_master.rd(16'h0139, q, v, e);
      `CHK({v, e, q}, {2'b11, 32'h00000000})
      u_dsp_master.wr(dsp_pkg::ADDR_COMMUT, 32'hffff0000);
      rchk(dsp_pkg::ADDR_COMMUT, 32'h00000000);
      `CHK(commut_mon_en, 1'b0)
      u_dsp_master.wr(dsp_pkg::ADDR_TOUT, 32'h00000007);
      ce <= 1'b0;
      u_dsp_master.wr(dsp_pkg::ADDR_TOUT, 32'h00000005);
      ce <= 1'b1;
      rchk(dsp_pkg::ADDR_TOUT, 32'h00000007);
      done("refused");
      nv_data_corrupt <= 1'b1;
      motor_absent <= 1'b1;
      @(posedge core_clk);
      first_setup_evt <= 1'b1;
      motor_changed_evt <= 1'b1;
      fork
         u_dsp_master.rd(dsp_pkg::ADDR_STARTUP, q, v, e);
         begin
            @(posedge core_clk);
            first_setup_evt <= 1'b0;
            motor_changed_evt <= 1'b0;
         end
      join
      `CHK(q, 32'h0000000f)
      u_dsp_master.confirm({30'($urandom_range(32'h3fffffff, 0)), 2'b01} & 32'hfffffff1);
      rchk(dsp_pkg::ADDR_STARTUP, 32'h0000000e);
      u_dsp_master.confirm(32'hfffffffe);
      nv_data_corrupt <= 1'b0;
      motor_absent <= 1'b0;
      cyc(2);
      rchk(dsp_pkg::ADDR_STARTUP, 32'h00000000);
      done("startup");
      u_dsp_master.wr(dsp_pkg::ADDR_TOL, 32'h0000000a);
      u_dsp_master.wr(dsp_pkg::ADDR_DWELL, 32'h00000003);
      ctrl_dev <= 32'hfffffffb;
      cyc(2 * TICK - 2);
      #1;
      `CHK(standstill, 1'b0)
      wait_hi(0, 2 * TICK + 8);
      ctrl_dev <= 32'h0000000b;
      cyc(3);
      #1;
      `CHK(standstill, 1'b0)
      ctrl_dev <= 32'h00000000;
      u_dsp_master.wr(dsp_pkg::ADDR_DWELL, 32'h00000000);
      cyc(5 * TICK);
      #1;
      `CHK(standstill, 1'b0)
      done("standstill");
      u_dsp_master.wr(dsp_pkg::ADDR_DWELL, 32'h00000003);
      ctrl_dev <= 32'h00100000;
      u_dsp_master.wr(dsp_pkg::ADDR_TOUT, 32'h00000002);
      target_reached <= 1'b1;
      @(posedge core_clk);
      target_reached <= 1'b0;
      cyc(TICK - 2);
      #1;
      `CHK(standstill_tout_err, 1'b0)
      wait_hi(1, 2 * TICK + 8);
      @(posedge core_clk);
      profile_done <= 1'b1;
      @(posedge core_clk);
      profile_done <= 1'b0;
      #1;
      `CHK(standstill_tout_err, 1'b0)
      wait_hi(1, 2 * TICK + 8);
      u_dsp_master.wr(dsp_pkg::ADDR_TOUT, 32'h00000000);
      cyc(2);
      #1;
      `CHK(standstill_tout_err, 1'b0)
      done("timeout");
      u_dsp_master.wr(dsp_pkg::ADDR_UPPER_LIM, 32'h000003e8);
      u_dsp_master.wr(dsp_pkg::ADDR_LOWER_LIM, 32'hfffffc18);
      actual_pos <= 32'h000007d0;
      cyc(3);
      #1;
      `CHK(lim_pos_hit, 1'b0)
      homing_done <= 1'b1;
      cyc(3);
      #1;
      `CHK({lim_pos_hit, lim_neg_hit}, 2'b10)
      actual_pos <= 32'hfffff830;
      cyc(3);
      #1;
      `CHK({lim_pos_hit, lim_neg_hit}, 2'b01)
      done("limits");
      resetn <= 1'b0;
      ctrl_variant <= 1'b0;
      cyc(4);
      resetn <= 1'b1;
      cyc(2);
      rchk(dsp_pkg::ADDR_MODES, dsp_pkg::MODES_BASIC);
      done("variant");
      tally_and_finish();
   end
endmodule
